/* File: core/sdrl_defines.svh */
// offsets, encodings and layout of the sdr read latency table
// assumes the table image lives in sdrl_table_rom and is read byte-wise
//
// Notes on behaviour
// - code 11b: no waits for plain, fast, quad-out; quad io 2 mode, 1 dummy
// - 80 MHz row uses code 00b; fast/quad-out 8 dummy; quad io 2+4
// - 90 MHz row uses code 01b; fast/quad-out 8 dummy; quad io 2+4
// - 104 MHz row uses code 10b; fast/quad-out 8 dummy; quad io 2+5
// - 133 MHz row supports only fast read, 0 mode, 8 dummy
// - FFh count means unsupported; plain read unsupported from 80 MHz up
// - dual-out and dual io reads unsupported in every row
// - quad io read always takes exactly two mode cycles when supported
// - fast read never has mode cycles, only the row's dummy count
// - quad-out read has no mode cycles; 8 dummy from 80 to 104 MHz
// - each row opens with frequency ceiling in MHz, then latency code
// - lowest row is 50 MHz (32h) and is selected by code 11b
// - header names commands by opcode: 03h, 0Bh, 6Bh, EBh
`ifndef SDRL_DEFINES_SVH
`define SDRL_DEFINES_SVH

// table geometry
`define SDRL_TBL_BYTES 7'h58
`define SDRL_ROW0_BASE 7'h12
`define SDRL_ROW_LEN 7'h0E
`define SDRL_UNSUPPORTED 8'hFF

// column offsets inside a row (mode byte; dummy byte follows)
`define SDRL_COL_PLAIN 7'h02
`define SDRL_COL_FAST 7'h04
`define SDRL_COL_DUAL_OUT 7'h06
`define SDRL_COL_QUAD_OUT 7'h08
`define SDRL_COL_DUAL_IO 7'h0A
`define SDRL_COL_QUAD_IO 7'h0C

// read opcodes, 3-byte and 4-byte address forms
`define SDRL_OP_PLAIN3 8'h03
`define SDRL_OP_PLAIN4 8'h13
`define SDRL_OP_FAST3 8'h0B
`define SDRL_OP_FAST4 8'h0C
`define SDRL_OP_QOUT3 8'h6B
`define SDRL_OP_QOUT4 8'h6C
`define SDRL_OP_QIO3 8'hEB
`define SDRL_OP_QIO4 8'hEC

// latency codes
`define SDRL_CODE_50 2'h3
`define SDRL_CODE_80 2'h0
`define SDRL_CODE_90 2'h1
`define SDRL_CODE_104 2'h2

// row indices
`define SDRL_ROW_50 3'h0
`define SDRL_ROW_80 3'h1
`define SDRL_ROW_90 3'h2
`define SDRL_ROW_104 3'h3
`define SDRL_ROW_133 3'h4

`endif

/* File: core/sdrl_pkg.sv */
// types shared by the latency lookup modules
// assumes sdrl_defines.svh for all numeric constants
package sdrl_pkg;

    typedef logic [7:0] sdrl_byte_t;
    typedef logic [6:0] sdrl_addr_t;

    // lookup sequencer, one-hot
    typedef enum logic [3:0] {
        LK_IDLE = 4'h1,
        LK_FREQ = 4'h2,
        LK_MODE = 4'h4,
        LK_FIN = 4'h8
    } sdrl_lk_e;

    // wait-cycle sequencer, one-hot
    typedef enum logic [2:0] {
        WT_IDLE = 3'h1,
        WT_MODE = 3'h2,
        WT_DUMMY = 3'h4
    } sdrl_wt_e;

endpackage

/* File: core/sdrl_rom_if.sv */
// carrier between the lookup top and its table memory
// assumes both ports are sampled on the same clock
`timescale 1ns/1ps
interface sdrl_rom_if;
    import sdrl_pkg::*;
    sdrl_addr_t a_addr;
    sdrl_byte_t a_data;
    sdrl_addr_t b_addr;
    sdrl_byte_t b_data;

    modport mem (input a_addr, input b_addr, output a_data, output b_data);
    modport user (output a_addr, output b_addr, input a_data, input b_data);
endinterface

/* File: core/sdrl_table_rom.sv */
// table image with two registered read ports
// assumes addresses are stable in the cycle before data is used
`timescale 1ns/1ps
`include "sdrl_defines.svh"
module sdrl_table_rom
    import sdrl_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // read ports
    sdrl_rom_if.mem rom
);

    // ========================================================
    // image
    // ========================================================
    localparam int DEPTH = 88;
    localparam sdrl_byte_t IMG [0:DEPTH-1] = '{
        // header: id, length, rows, row length, "F", "C"
        8'h90, 8'h56, 8'h06, 8'h0E, 8'h46, 8'h43,
        // opcode columns
        8'h03, 8'h13, 8'h0B, 8'h0C, 8'hFF, 8'hFF,
        8'h6B, 8'h6C, 8'hFF, 8'hFF, 8'hEB, 8'hEC,
        // 50 MHz, code 11b
        8'h32, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF,
        8'hFF, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h02, 8'h01,
        // 80 MHz, code 00b
        8'h50, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h08, 8'hFF,
        8'hFF, 8'h00, 8'h08, 8'hFF, 8'hFF, 8'h02, 8'h04,
        // 90 MHz, code 01b
        8'h5A, 8'h01, 8'hFF, 8'hFF, 8'h00, 8'h08, 8'hFF,
        8'hFF, 8'h00, 8'h08, 8'hFF, 8'hFF, 8'h02, 8'h04,
        // 104 MHz, code 10b
        8'h68, 8'h02, 8'hFF, 8'hFF, 8'h00, 8'h08, 8'hFF,
        8'hFF, 8'h00, 8'h08, 8'hFF, 8'hFF, 8'h02, 8'h05,
        // 133 MHz, code 10b, fast read only
        8'h85, 8'h02, 8'hFF, 8'hFF, 8'h00, 8'h08, 8'hFF,
        8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF
    };

    // ========================================================
    // read ports
    // ========================================================
    // out-of-range reads answer as unsupported rather than wrap
    wire logic a_in = rom.a_addr < `SDRL_TBL_BYTES;
    wire logic b_in = rom.b_addr < `SDRL_TBL_BYTES;
    wire sdrl_byte_t a_val = a_in ? IMG[rom.a_addr] : `SDRL_UNSUPPORTED;
    wire sdrl_byte_t b_val = b_in ? IMG[rom.b_addr] : `SDRL_UNSUPPORTED;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rom.a_data <= 8'h00;
            rom.b_data <= 8'h00;
        end else begin
            rom.a_data <= a_val;
            rom.b_data <= b_val;
        end
    end

endmodule // sdrl_table_rom

/* File: core/sdr_latency_lookup.sv */
// sdr read latency lookup: row select, table fetch, wait-cycle sequencer
// assumes all inputs come from logic on ref_clk; sck_tick marks serial edges
`timescale 1ns/1ps
`include "sdrl_defines.svh"
module sdr_latency_lookup
    import sdrl_pkg::*;
#(
    parameter int ADDR_W = 7
)(
    // clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // lookup request
    input wire logic lookup_req,
    input wire logic [1:0] latency_code,
    input wire logic fast_row_sel,
    input wire logic [7:0] read_opcode,
    // lookup answer
    output logic lookup_busy,
    output logic lookup_valid,
    output logic cmd_supported,
    output logic [7:0] mode_cycles,
    output logic [7:0] dummy_cycles,
    output logic [7:0] freq_mhz,
    // wait-cycle sequencer
    input wire logic sck_tick,
    input wire logic wait_start,
    output logic mode_phase,
    output logic dummy_phase,
    output logic wait_done,
    output logic wait_refused,
    // raw table read
    input wire logic tbl_rd_en,
    input wire logic [ADDR_W-1:0] tbl_addr,
    output logic tbl_rd_valid,
    output logic [7:0] tbl_rd_data
);

    // ========================================================
    // elaboration checks
    // ========================================================
    // the table image is fixed at 88 bytes behind a 7-bit address
    if (ADDR_W != 7) begin : g_bad_addr_w
        $error("sdr_latency_lookup: ADDR_W must be 7");
    end

    sdrl_rom_if rom ();

    sdrl_table_rom u_rom (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .rom(rom)
    );

    // ========================================================
    // request decode
    // ========================================================
    sdrl_lk_e lk_q;
    sdrl_lk_e lk_d;
    logic [2:0] row_q;
    logic [6:0] col_q;
    logic known_q;
    logic res_ok_q;
    logic fin_q;

    // code 10b covers both the 104 and 133 MHz rows; host says which
    wire logic [2:0] row_sel =
        (latency_code == `SDRL_CODE_50) ? `SDRL_ROW_50 :
        (latency_code == `SDRL_CODE_80) ? `SDRL_ROW_80 :
        (latency_code == `SDRL_CODE_90) ? `SDRL_ROW_90 :
        fast_row_sel ? `SDRL_ROW_133 : `SDRL_ROW_104;

    wire logic op_plain = read_opcode == `SDRL_OP_PLAIN3 ||
        read_opcode == `SDRL_OP_PLAIN4;
    wire logic op_fast = read_opcode == `SDRL_OP_FAST3 ||
        read_opcode == `SDRL_OP_FAST4;
    wire logic op_qout = read_opcode == `SDRL_OP_QOUT3 ||
        read_opcode == `SDRL_OP_QOUT4;
    wire logic op_qio = read_opcode == `SDRL_OP_QIO3 ||
        read_opcode == `SDRL_OP_QIO4;

    // opcodes outside the table (dual reads included) fetch a dual column
    wire logic [6:0] col_sel =
        op_plain ? `SDRL_COL_PLAIN :
        op_fast ? `SDRL_COL_FAST :
        op_qout ? `SDRL_COL_QUAD_OUT :
        op_qio ? `SDRL_COL_QUAD_IO : `SDRL_COL_DUAL_IO;

    wire logic op_known = op_plain || op_fast || op_qout || op_qio;

    wire logic [6:0] row_base = `SDRL_ROW0_BASE +
        7'(row_q) * `SDRL_ROW_LEN;
    wire logic [6:0] mode_addr = row_base + col_q;
    wire logic [6:0] dummy_addr = mode_addr + 7'h01;

    // ========================================================
    // lookup sequencer
    // ========================================================
    // freq byte first, then mode, then dummy; rom answers a cycle later
    assign rom.a_addr = (lk_q == LK_FREQ) ? row_base :
        (lk_q == LK_MODE) ? mode_addr : dummy_addr;
    assign rom.b_addr = tbl_addr;

    // no take in the cycle the dummy byte is still being captured
    wire logic take_req = (lk_q == LK_IDLE) && !fin_q && lookup_req;

    always_comb begin
        lk_d = lk_q;
        case (lk_q)
            LK_IDLE: begin
                if (take_req) begin
                    lk_d = LK_FREQ;
                end
            end
            LK_FREQ: lk_d = LK_MODE;
            LK_MODE: lk_d = LK_FIN;
            LK_FIN: lk_d = LK_IDLE;
            default: lk_d = LK_IDLE;
        endcase
    end

    // mode byte is in hand during fin, dummy byte in the cycle after it
    wire logic [7:0] mode_val = known_q ? rom.a_data : `SDRL_UNSUPPORTED;
    wire logic [7:0] dummy_val = known_q ? rom.a_data : `SDRL_UNSUPPORTED;

    // FFh in either count, or an unknown opcode, means unsupported
    wire logic fin_ok = known_q && (mode_cycles != `SDRL_UNSUPPORTED) &&
        (dummy_val != `SDRL_UNSUPPORTED);

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            lk_q <= LK_IDLE;
            row_q <= 3'h0;
            col_q <= 7'h00;
            known_q <= 1'b0;
        end else begin
            lk_q <= lk_d;
            if (take_req) begin
                row_q <= row_sel;
                col_q <= col_sel;
                known_q <= op_known;
            end
        end
    end

    // ========================================================
    // result registers
    // ========================================================
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            fin_q <= 1'b0;
        end else begin
            fin_q <= lk_q == LK_FIN;
        end
    end

    // busy spans the dummy capture cycle, in which nothing is taken
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            lookup_valid <= 1'b0;
            lookup_busy <= 1'b0;
        end else begin
            lookup_valid <= fin_q;
            lookup_busy <= (lk_d != LK_IDLE) || (lk_q == LK_FIN);
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            freq_mhz <= 8'h00;
        end else if (lk_q == LK_MODE) begin
            freq_mhz <= rom.a_data;
        end
    end

    // mode count may move a cycle before valid; read it at valid only
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_cycles <= 8'h00;
        end else if (lk_q == LK_FIN) begin
            mode_cycles <= mode_val;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            dummy_cycles <= 8'h00;
            cmd_supported <= 1'b0;
        end else if (fin_q) begin
            dummy_cycles <= dummy_val;
            cmd_supported <= fin_ok;
        end
    end

    // a fresh take voids the last result until its own fin
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            res_ok_q <= 1'b0;
        end else if (fin_q) begin
            res_ok_q <= fin_ok;
        end else if (take_req) begin
            res_ok_q <= 1'b0;
        end
    end

    // ========================================================
    // wait-cycle sequencer
    // ========================================================
    // counts serial ticks: mode cycles, then dummy cycles, of the last
    // good lookup; the dummy count is latched at start, so a lookup that
    // runs during a wait cannot stretch or cut it
    sdrl_wt_e wt_q;
    sdrl_wt_e wt_d;
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic [7:0] dum_q;

    wire logic can_start = (wt_q == WT_IDLE) && res_ok_q &&
        (lk_q == LK_IDLE) && !fin_q;
    wire logic go = wait_start && can_start;
    wire logic has_mode = mode_cycles != 8'h00;
    wire logic has_dummy = dummy_cycles != 8'h00;
    wire logic dum_left = dum_q != 8'h00;
    wire logic last = sck_tick && (cnt_q == 8'h00);
    logic fin_d;

    always_comb begin
        wt_d = wt_q;
        cnt_d = cnt_q;
        fin_d = 1'b0;
        case (wt_q)
            WT_IDLE: begin
                if (go && has_mode) begin
                    wt_d = WT_MODE;
                    cnt_d = mode_cycles - 8'h01;
                end else if (go && has_dummy) begin
                    wt_d = WT_DUMMY;
                    cnt_d = dummy_cycles - 8'h01;
                end else if (go) begin
                    fin_d = 1'b1;
                end
            end
            WT_MODE: begin
                if (last && dum_left) begin
                    wt_d = WT_DUMMY;
                    cnt_d = dum_q - 8'h01;
                end else if (last) begin
                    wt_d = WT_IDLE;
                    fin_d = 1'b1;
                end else if (sck_tick) begin
                    cnt_d = cnt_q - 8'h01;
                end
            end
            WT_DUMMY: begin
                if (last) begin
                    wt_d = WT_IDLE;
                    fin_d = 1'b1;
                end else if (sck_tick) begin
                    cnt_d = cnt_q - 8'h01;
                end
            end
            default: wt_d = WT_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            wt_q <= WT_IDLE;
            cnt_q <= 8'h00;
        end else begin
            wt_q <= wt_d;
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            dum_q <= 8'h00;
        end else if (go) begin
            dum_q <= dummy_cycles;
        end
    end

    // phases are decoded from the next state so they line up with wt_q
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_phase <= 1'b0;
            dummy_phase <= 1'b0;
            wait_done <= 1'b0;
            wait_refused <= 1'b0;
        end else begin
            mode_phase <= wt_d == WT_MODE;
            dummy_phase <= wt_d == WT_DUMMY;
            wait_done <= fin_d;
            wait_refused <= wait_start && !can_start;
        end
    end

    // ========================================================
    // raw table read
    // ========================================================
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            tbl_rd_valid <= 1'b0;
        end else begin
            tbl_rd_valid <= tbl_rd_en;
        end
    end
    assign tbl_rd_data = rom.b_data;

endmodule // sdr_latency_lookup

/* File: dv/sdrl_host_model.sv */
// host-side serial clock pacing for the lookup wait sequencer
// assumes ref_clk domain; ticks only while a frame runs
`timescale 1ns/1ps
module sdrl_host_model (
    // clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // pacing control
    input wire logic run,
    input wire logic [3:0] div,
    // serial clock enable
    output logic sck_tick
);
    logic [3:0] cnt_q;
    // ==========================================
    // tick generator
    // serial clock stands still between frames
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= 4'h0;
            sck_tick <= 1'b0;
        end else begin
            cnt_q <= (!run || cnt_q + 4'h1 >= div) ? 4'h0 : cnt_q + 4'h1;
            sck_tick <= run && (cnt_q + 4'h1 >= div);
        end
    end
endmodule // sdrl_host_model

/* File: dv/sdrl_lookup_asserts.sv */
// timing checks on the latency lookup ports
// assumes single ref_clk domain, arst_n active low
`timescale 1ns/1ps
module sdrl_lookup_asserts (
    // clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // lookup
    input wire logic lookup_req,
    input wire logic [1:0] latency_code,
    input wire logic lookup_busy,
    input wire logic lookup_valid,
    input wire logic cmd_supported,
    input wire logic [7:0] mode_cycles,
    input wire logic [7:0] dummy_cycles,
    input wire logic [7:0] freq_mhz,
    // waits and raw read
    input wire logic wait_start,
    input wire logic mode_phase,
    input wire logic dummy_phase,
    input wire logic wait_done,
    input wire logic wait_refused,
    input wire logic tbl_rd_en,
    input wire logic tbl_rd_valid
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    // ==========================================
    // sequences
    sequence s_take;
        $rose(lookup_busy);
    endsequence
    sequence s_answer;
        !lookup_valid [*4] ##1 lookup_valid;
    endsequence
    // ==========================================
    // assertions
    chk_lookup_lat: assert property (s_take |-> s_answer)
        else $error("lookup answer late or early");
    chk_valid_pulse: assert property (lookup_valid |=> !lookup_valid)
        else $error("lookup valid longer than one cycle");
    chk_busy_drop: assert property (lookup_valid |-> !lookup_busy)
        else $error("busy still high at answer");
    chk_qio_mode: assert property (lookup_valid && cmd_supported
        && mode_cycles != 8'h00 |-> mode_cycles == 8'h02)
        else $error("mode count not two");
    chk_unsup_flag: assert property (lookup_valid |->
        cmd_supported == (mode_cycles != 8'hFF && dummy_cycles != 8'hFF))
        else $error("support flag disagrees with counts");
    chk_low_row: assert property (lookup_valid
        && latency_code == 2'h3 |-> freq_mhz == 8'h32)
        else $error("code three not lowest row");
    chk_rd_valid: assert property (tbl_rd_en |=> tbl_rd_valid)
        else $error("raw read not answered");
    chk_phase_excl: assert property (!(mode_phase && dummy_phase))
        else $error("both phases high");
    chk_refuse_start: assert property (wait_start && !cmd_supported
        && !lookup_busy && !lookup_req |=> wait_refused)
        else $error("bad wait start not refused");
    chk_done_clear: assert property (wait_done |->
        !mode_phase && !dummy_phase ##1 !wait_done)
        else $error("done overlaps phase or lasts");
endmodule // sdrl_lookup_asserts

bind sdr_latency_lookup sdrl_lookup_asserts u_chk (.ref_clk, .arst_n,
    .lookup_req, .latency_code, .lookup_busy, .lookup_valid, .cmd_supported,
    .mode_cycles, .dummy_cycles, .freq_mhz, .wait_start, .mode_phase,
    .dummy_phase, .wait_done, .wait_refused, .tbl_rd_en, .tbl_rd_valid);

/* File: dv/sdr_latency_lookup_bench.sv */
// self-checking bench for the sdr latency lookup
// assumes host model paces sck_tick; table as documented
`timescale 1ns/1ps
module sdr_latency_lookup_bench;
    logic ref_clk = 0, arst_n = 0, lookup_req = 0, fast_row_sel = 0;
    logic [1:0] latency_code = 0;
    logic [7:0] read_opcode = 0, mode_cycles, dummy_cycles, freq_mhz;
    logic lookup_busy, lookup_valid, cmd_supported, sck_tick, wait_start = 0;
    logic mode_phase, dummy_phase, wait_done, wait_refused, tbl_rd_en = 0;
    logic [6:0] tbl_addr = 0;
    logic tbl_rd_valid, run = 0;
    logic [7:0] tbl_rd_data;
    logic [3:0] div = 4'h1;
    int n_errors = 0, checks = 0;
    localparam logic [7:0] FREQ [5] = '{8'h32, 8'h50, 8'h5A, 8'h68, 8'h85};
    localparam logic [1:0] CODE [5] = '{2'h3, 2'h0, 2'h1, 2'h2, 2'h2};
    localparam logic [7:0] OPS [9] = '{8'h03, 8'h0B, 8'h6B, 8'hEB, 8'h13,
        8'h0C, 8'h6C, 8'hEC, 8'h3B};

    always #5 ref_clk = ~ref_clk;

    sdr_latency_lookup DUT (.ref_clk, .arst_n, .lookup_req, .latency_code,
        .fast_row_sel, .read_opcode, .lookup_busy, .lookup_valid,
        .cmd_supported, .mode_cycles, .dummy_cycles, .freq_mhz, .sck_tick,
        .wait_start, .mode_phase, .dummy_phase, .wait_done, .wait_refused,
        .tbl_rd_en, .tbl_addr, .tbl_rd_valid, .tbl_rd_data);
    sdrl_host_model u_host (.ref_clk, .arst_n, .run, .div, .sck_tick);

    // ==========================================
    // helpers
    task summarize;
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task hang;
        n_errors++;
        $display("ERROR %0t wait bound used up", $time);
        summarize();
    endtask
    // c: 0 plain, 1 fast, 2 quad out, 3 quad io, 4 dual
    function automatic logic [23:0] expect_row(int r, int c);
        logic [7:0] m, d;
        m = (c == 3) ? 8'h02 : 8'h00;
        case (r)
            0: d = (c == 3) ? 8'h01 : 8'h00;
            3: d = (c == 3) ? 8'h05 : 8'h08;
            default: d = (c == 3) ? 8'h04 : 8'h08;
        endcase
        if ((r > 0 && c == 0) || (r == 4 && c != 1) || c == 4) begin
            m = 8'hFF;
            d = 8'hFF;
        end
        return {FREQ[r], m, d};
    endfunction
    task automatic look(input int r, input logic [7:0] op);
        int n;
        @(posedge ref_clk);
        lookup_req <= 1'b1;
        latency_code <= CODE[r];
        fast_row_sel <= (r == 4);
        read_opcode <= op;
        @(posedge ref_clk);
        lookup_req <= 1'b0;
        n = 0;
        do begin
            @(posedge ref_clk);
            #1;
            n++;
        end while (lookup_valid !== 1'b1 && n < 10);
        if (n >= 10) hang();
        chk(8'(n), 8'h04);
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        tbl_rd_en <= 1'b1;
        tbl_addr <= a;
        @(posedge ref_clk);
        tbl_rd_en <= 1'b0;
        #1;
        chk({7'h0, tbl_rd_valid}, 8'h01);
        chk(tbl_rd_data, e);
    endtask

    // ==========================================
    // scenarios
    task automatic t_table;
        logic [23:0] e;
        for (int r = 0; r < 5; r++) begin
            for (int i = 0; i < 9; i++) begin
                e = expect_row(r, (i == 8) ? 4 : i % 4);
                look(r, OPS[i]);
                chk(freq_mhz, e[23:16]);
                chk(mode_cycles, e[15:8]);
                chk(dummy_cycles, e[7:0]);
                chk({7'h0, cmd_supported}, {7'h0, e[7:0] != 8'hFF});
            end
        end
        $display("table sweep done");
    endtask
    task automatic t_raw;
        rd(7'h00, 8'h90);
        for (int r = 0; r < 5; r++) begin
            rd(7'h12 + 7'(r * 14), FREQ[r]);
            rd(7'h13 + 7'(r * 14), {6'h0, CODE[r]});
        end
        rd(7'h57, 8'hFF);
        rd(7'h7F, 8'hFF);
        $display("raw read done");
    endtask
    task automatic wt(input int r, input logic [7:0] op, input logic [3:0] dv,
        input logic [7:0] em, input logic [7:0] ed);
        int n;
        logic [7:0] m, d;
        look(r, op);
        m = 0;
        d = 0;
        @(posedge ref_clk);
        wait_start <= 1'b1;
        div <= dv;
        run <= 1'b1;
        @(posedge ref_clk);
        wait_start <= 1'b0;
        for (n = 0; n < 200; n++) begin
            #1;
            if (mode_phase && sck_tick) m++;
            if (dummy_phase && sck_tick) d++;
            if (wait_done === 1'b1) break;
            @(posedge ref_clk);
        end
        if (n >= 200) hang();
        @(posedge ref_clk);
        run <= 1'b0;
        chk(m, em);
        chk(d, ed);
    endtask
    task automatic t_wait;
        wt(0, 8'hEB, 4'h1, 8'h02, 8'h01);
        wt(3, 8'hEB, 4'h3, 8'h02, 8'h05);
        wt(0, 8'h0B, 4'h2, 8'h00, 8'h00);
        $display("wait sequencing done");
    endtask
    task automatic t_refuse;
        look(4, 8'hEB);
        @(posedge ref_clk);
        wait_start <= 1'b1;
        @(posedge ref_clk);
        wait_start <= 1'b0;
        #1;
        chk({7'h0, wait_refused}, 8'h01);
        chk({7'h0, mode_phase}, 8'h00);
        $display("refusal done");
    endtask

    initial begin
        repeat (12) @(posedge ref_clk);
        arst_n <= 1'b1;
        t_raw();
        t_table();
        t_wait();
        t_refuse();
        summarize();
    end
endmodule // sdr_latency_lookup_bench
